// ==== inc/uart_control_two_params.svh ====
// Register map, field positions, reset values and frame counts of the serial control block
`ifndef UART_CONTROL_TWO_PARAMS_SVH
`define UART_CONTROL_TWO_PARAMS_SVH

`define OFS_CTRL_ONE     8'h00
`define OFS_CTRL_TWO     8'h04
`define OFS_FLAGS        8'h08
`define OFS_DATA         8'h0C
`define OFS_EV_STATUS    8'h10
`define OFS_EV_CLEAR     8'h14
`define OFS_EV_ENABLE    8'h18

`define C2_TX_EMPTY_IE   7
`define C2_TX_DONE_IE    6
`define C2_RX_FULL_IE    5
`define C2_QUIET_IE      4
`define C2_TX_ON         3
`define C2_RX_ON         2
`define C2_RX_STANDBY    1
`define C2_BREAK_QUEUE   0
`define C2_RESET         8'h00

`define C1_LOOPBACK      7
`define C1_RX_SOURCE     5
`define C1_NINE_BIT      4
`define C1_WAKE_MARK     3
`define C1_LONG_BREAK    1
`define C1_ONE_WIRE_DIR  0
`define C1_RESET         8'h00

`define FL_TX_EMPTY      3
`define FL_TX_DONE       2
`define FL_RX_FULL       1
`define FL_QUIET         0
`define FLAGS_RESET      4'hC

`define EV_BREAK_DONE    0
`define EV_WAKEUP        1
`define EV_FRAME_ERR     2
`define EV_WIDTH         3

`define FRAME_BITS_8     4'hA
`define FRAME_BITS_9     4'hB
`define BREAK_BITS_LONG8 4'hD
`define BREAK_BITS_LONG9 4'hE
`define BIT_CYCLES_DEF   16

`endif

// ==== inc/uart_control_two_pkg.sv ====
// Types shared by the serial control block
package uart_control_two_pkg;
    typedef enum logic [1:0] {TX_IDLE, TX_DATA, TX_BREAK, TX_PREAMBLE} tx_state_t;
    typedef enum logic {RX_WAIT, RX_BITS} rx_state_t;
    typedef logic [7:0] apb_addr_t;
endpackage

// ==== design/uart_control_two.sv ====
// Serial interface with its second control register, reached over APB
`timescale 1ns/100ps
`default_nettype none
`include "uart_control_two_params.svh"

module uart_control_two
#(
    parameter int BIT_CYCLES = `BIT_CYCLES_DEF
) (
    // Clock and reset
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    // APB slave
    input  wire uart_control_two_pkg::apb_addr_t paddr,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [31:0]                   pwdata,
    output logic      [31:0]                   prdata,
    output logic                               pready,
    output logic                               pslverr,
    // Serial pins
    output logic                               tx_pin_out,
    output logic                               tx_pin_oe,
    input  wire logic                          tx_pin_in,
    input  wire logic                          rx_pin_in,
    output logic                               rx_pin_claim,
    // Interrupt
    output logic                               irq
);
    import uart_control_two_pkg::*;

    localparam logic [15:0] BIT_LAST = 16'(BIT_CYCLES - 1);
    localparam logic [15:0] BIT_HALF = 16'(BIT_CYCLES / 2);

    // Registered state
    logic [7:0]            ctrl_one, ctrl_two;
    logic [3:0]            flags;
    logic [8:0]            tx_buf, rx_buf;
    logic [`EV_WIDTH-1:0]  ev_status, ev_enable;
    tx_state_t             tx_state;
    rx_state_t             rx_state;
    logic [15:0]           tx_cnt, rx_cnt;
    logic [3:0]            tx_left, rx_idx, quiet_bits;
    logic [10:0]           tx_shift;
    logic [9:0]            rx_shift;
    logic                  break_pend, idle_pend, rx_active, quiet_armed, tx_out;
    logic                  rx_s1, rx_s2, txp_s1, txp_s2;

    // Next values
    logic [7:0]            next_ctrl_one, next_ctrl_two;
    logic [3:0]            next_flags;
    logic [8:0]            next_tx_buf, next_rx_buf;
    logic [`EV_WIDTH-1:0]  next_ev_status, next_ev_enable, ev_set;
    tx_state_t             next_tx_state;
    rx_state_t             next_rx_state;
    logic [15:0]           next_tx_cnt, next_rx_cnt;
    logic [3:0]            next_tx_left, next_rx_idx, next_quiet_bits;
    logic [10:0]           next_tx_shift;
    logic [9:0]            next_rx_shift;
    logic                  next_break_pend, next_idle_pend, next_rx_active;
    logic                  next_quiet_armed, next_tx_out;
    // Decoded helpers
    logic        wr, rd, mapped, loop, one_wire, nine, tx_tick, rx_tick, rx_line, tx_owned;
    logic [3:0]  frame_len, break_len, last_idx;
    logic        rx_msb;

    assign wr   = psel & penable & pwrite;
    assign rd   = psel & penable & ~pwrite;
    assign loop = ctrl_one[`C1_LOOPBACK];
    assign one_wire = loop & ctrl_one[`C1_RX_SOURCE];
    assign nine = ctrl_one[`C1_NINE_BIT];
    assign frame_len = nine ? `FRAME_BITS_9 : `FRAME_BITS_8;
    assign break_len = ctrl_one[`C1_LONG_BREAK] ? (nine ? `BREAK_BITS_LONG9 : `BREAK_BITS_LONG8)
                                                : frame_len;
    assign last_idx = frame_len - 4'h2;
    assign tx_tick  = (tx_cnt == BIT_LAST);
    assign rx_tick  = (rx_cnt == BIT_LAST);
    assign rx_msb   = nine ? rx_shift[8] : rx_shift[7];

    always_comb begin
        unique case (paddr)
            `OFS_CTRL_ONE, `OFS_CTRL_TWO, `OFS_FLAGS, `OFS_DATA,
            `OFS_EV_STATUS, `OFS_EV_CLEAR, `OFS_EV_ENABLE: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // Zero wait states; unmapped addresses answer with an error
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    // Receiver input source: loopback uses the transmitter, single wire with the pin released (input direction) the shared pin
    always_comb begin
        if (!loop) begin
            rx_line = rx_s2;
        end else if (one_wire && !ctrl_one[`C1_ONE_WIRE_DIR]) begin
            rx_line = txp_s2;
        end else begin
            rx_line = tx_out;
        end
    end

    // Pin ownership
    assign tx_owned     = ctrl_two[`C2_TX_ON] | (tx_state != TX_IDLE)
                        | break_pend | idle_pend;
    assign tx_pin_oe    = tx_owned & ~(one_wire & ~ctrl_one[`C1_ONE_WIRE_DIR]);
    assign tx_pin_out   = tx_out;
    assign rx_pin_claim = ctrl_two[`C2_RX_ON] & ~loop;

    // Flag interrupts with their enables, plus the sticky event interrupts
    assign irq = |(flags & ctrl_two[`C2_TX_EMPTY_IE:`C2_QUIET_IE])
               | |(ev_status & ev_enable);

    always_comb begin
        next_ctrl_one    = ctrl_one;
        next_ctrl_two    = ctrl_two;
        next_flags       = flags;
        next_tx_buf      = tx_buf;
        next_rx_buf      = rx_buf;
        next_ev_enable   = ev_enable;
        ev_set           = '0;
        next_tx_state    = tx_state;
        next_rx_state    = rx_state;
        next_tx_cnt      = tx_cnt;
        next_rx_cnt      = rx_cnt;
        next_tx_left     = tx_left;
        next_rx_idx      = rx_idx;
        next_quiet_bits  = quiet_bits;
        next_tx_shift    = tx_shift;
        next_rx_shift    = rx_shift;
        next_break_pend  = break_pend;
        next_idle_pend   = idle_pend;
        next_rx_active   = rx_active;
        next_quiet_armed = quiet_armed;
        next_tx_out      = tx_out;

        // Software side first; hardware below overrides so a hardware set wins over a software clear, except for done
        if (wr) begin
            unique case (paddr)
                `OFS_CTRL_ONE: next_ctrl_one = pwdata[7:0];
                `OFS_CTRL_TWO: begin
                    next_ctrl_two = pwdata[7:0];
                    if (pwdata[`C2_TX_ON] && !ctrl_two[`C2_TX_ON]) begin
                        next_idle_pend = 1'b1;
                        next_flags[`FL_TX_DONE] = 1'b0;
                    end
                    if (pwdata[`C2_BREAK_QUEUE]) begin
                        next_break_pend = 1'b1;
                        next_flags[`FL_TX_DONE] = 1'b0;
                    end
                end
                `OFS_DATA: begin
                    next_tx_buf = pwdata[8:0];
                    next_flags[`FL_TX_EMPTY] = 1'b0;
                    next_flags[`FL_TX_DONE]  = 1'b0;
                end
                `OFS_EV_ENABLE: next_ev_enable = pwdata[`EV_WIDTH-1:0];
                default: ;
            endcase
        end
        if (rd && paddr == `OFS_DATA) begin
            next_flags[`FL_RX_FULL] = 1'b0;
            next_flags[`FL_QUIET]   = 1'b0;
        end

        // Transmitter
        next_tx_cnt = (tx_state == TX_IDLE || tx_tick) ? 16'h0000 : tx_cnt + 16'h0001;
        unique case (tx_state)
            TX_IDLE: begin
                next_tx_out = 1'b1;
                if (idle_pend) begin
                    next_idle_pend = 1'b0;
                    next_tx_left   = frame_len;
                    next_tx_state  = TX_PREAMBLE;
                end else if (break_pend || ctrl_two[`C2_BREAK_QUEUE]) begin
                    next_break_pend = 1'b0;
                    next_tx_left    = break_len;
                    next_tx_out     = 1'b0;
                    next_tx_state   = TX_BREAK;
                end else if (ctrl_two[`C2_TX_ON] && !flags[`FL_TX_EMPTY]) begin
                    next_tx_shift = nine ? {1'b1, tx_buf, 1'b0} : {2'b11, tx_buf[7:0], 1'b0};
                    next_tx_left  = frame_len;
                    next_tx_out   = 1'b0;
                    next_flags[`FL_TX_EMPTY] = 1'b1;
                    next_tx_state = TX_DATA;
                // A data, idle or break request landing this cycle keeps done low
                end else if (next_flags[`FL_TX_EMPTY] && !next_idle_pend && !next_break_pend) begin
                    next_flags[`FL_TX_DONE] = 1'b1;
                end
            end
            TX_DATA, TX_BREAK, TX_PREAMBLE: begin
                if (tx_tick) begin
                    next_tx_left  = tx_left - 4'h1;
                    next_tx_shift = {1'b1, tx_shift[10:1]};
                    if (tx_state == TX_DATA) begin
                        next_tx_out = tx_shift[1];
                    end
                    if (tx_left == 4'h1) begin
                        next_tx_out   = 1'b1;
                        next_tx_state = TX_IDLE;
                        ev_set[`EV_BREAK_DONE] = (tx_state == TX_BREAK);
                    end
                end
            end
        endcase

        // Receiver
        next_rx_cnt = (rx_tick) ? 16'h0000 : rx_cnt + 16'h0001;
        unique case (rx_state)
            RX_WAIT: begin
                if (!ctrl_two[`C2_RX_ON]) begin
                    next_quiet_bits = 4'h0;
                end else if (!rx_line) begin
                    next_rx_cnt     = BIT_HALF;
                    next_rx_idx     = 4'hF;
                    next_rx_active  = 1'b1;
                    next_quiet_bits = 4'h0;
                    next_rx_state   = RX_BITS;
                end else if (rx_tick && rx_active) begin
                    next_quiet_bits = quiet_bits + 4'h1;
                    if (quiet_bits + 4'h1 == frame_len) begin
                        // One event per idle period: activity must be seen again first
                        next_rx_active = 1'b0;
                        if (quiet_armed) begin
                            next_flags[`FL_QUIET] = 1'b1;
                            next_quiet_armed = 1'b0;
                        end
                        if (ctrl_two[`C2_RX_STANDBY] && !ctrl_one[`C1_WAKE_MARK]) begin
                            next_ctrl_two[`C2_RX_STANDBY] = 1'b0;
                            ev_set[`EV_WAKEUP] = 1'b1;
                        end
                    end
                end
            end
            RX_BITS: begin
                if (rx_tick) begin
                    next_rx_idx = rx_idx + 4'h1;
                    if (rx_idx == 4'hF) begin
                        if (rx_line) begin
                            next_rx_state = RX_WAIT; // false start
                        end
                    end else begin
                        next_rx_shift[rx_idx] = rx_line;
                    end
                    if (rx_idx == last_idx) begin
                        next_rx_state = RX_WAIT;
                        ev_set[`EV_FRAME_ERR] = ~rx_line;
                    end
                end
            end
        endcase
        // Character complete: taken unless the receiver sleeps
        if (rx_state == RX_BITS && rx_tick && rx_idx == last_idx) begin
            if (ctrl_two[`C2_RX_STANDBY] && ctrl_one[`C1_WAKE_MARK] && rx_msb) begin
                next_ctrl_two[`C2_RX_STANDBY] = 1'b0;
                ev_set[`EV_WAKEUP] = 1'b1;
            end
            if (!ctrl_two[`C2_RX_STANDBY] || next_ctrl_two[`C2_RX_STANDBY] == 1'b0) begin
                next_rx_buf = nine ? rx_shift[8:0] : {1'b0, rx_shift[7:0]};
                next_flags[`FL_RX_FULL] = 1'b1;
                next_quiet_armed = 1'b1;
            end
        end

        // Sticky events: a clear write never swallows a same-cycle event
        next_ev_status = ((wr && paddr == `OFS_EV_CLEAR) ? ev_status & ~pwdata[`EV_WIDTH-1:0]
                                                         : ev_status) | ev_set;
    end

    always_comb begin
        prdata = 32'h0000_0000;
        if (rd) begin
            unique case (paddr)
                `OFS_CTRL_ONE:  prdata[7:0] = ctrl_one;
                `OFS_CTRL_TWO:  prdata[7:0] = ctrl_two;
                `OFS_FLAGS:     prdata[3:0] = flags;
                `OFS_DATA:      prdata[8:0] = rx_buf;
                `OFS_EV_STATUS: prdata[`EV_WIDTH-1:0] = ev_status;
                `OFS_EV_ENABLE: prdata[`EV_WIDTH-1:0] = ev_enable;
                default: ;
            endcase
        end
    end

    // Pin synchronisers: the first stage feeds only the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_s1  <= 1'b1;
            rx_s2  <= 1'b1;
            txp_s1 <= 1'b1;
            txp_s2 <= 1'b1;
        end else begin
            rx_s1  <= rx_pin_in;
            rx_s2  <= rx_s1;
            txp_s1 <= tx_pin_in;
            txp_s2 <= txp_s1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_one    <= `C1_RESET;
            ctrl_two    <= `C2_RESET;
            flags       <= `FLAGS_RESET;
            tx_buf      <= 9'h000;
            rx_buf      <= 9'h000;
            ev_status   <= '0;
            ev_enable   <= '0;
            tx_state    <= TX_IDLE;
            rx_state    <= RX_WAIT;
            tx_cnt      <= 16'h0000;
            rx_cnt      <= 16'h0000;
            tx_left     <= 4'h0;
            rx_idx      <= 4'h0;
            quiet_bits  <= 4'h0;
            tx_shift    <= 11'h7FF;
            rx_shift    <= 10'h000;
            break_pend  <= 1'b0;
            idle_pend   <= 1'b0;
            rx_active   <= 1'b0;
            quiet_armed <= 1'b0;
            tx_out      <= 1'b1;
        end else begin
            ctrl_one    <= next_ctrl_one;
            ctrl_two    <= next_ctrl_two;
            flags       <= next_flags;
            tx_buf      <= next_tx_buf;
            rx_buf      <= next_rx_buf;
            ev_status   <= next_ev_status;
            ev_enable   <= next_ev_enable;
            tx_state    <= next_tx_state;
            rx_state    <= next_rx_state;
            tx_cnt      <= next_tx_cnt;
            rx_cnt      <= next_rx_cnt;
            tx_left     <= next_tx_left;
            rx_idx      <= next_rx_idx;
            quiet_bits  <= next_quiet_bits;
            tx_shift    <= next_tx_shift;
            rx_shift    <= next_rx_shift;
            break_pend  <= next_break_pend;
            idle_pend   <= next_idle_pend;
            rx_active   <= next_rx_active;
            quiet_armed <= next_quiet_armed;
            tx_out      <= next_tx_out;
        end
    end
endmodule
`default_nettype wire

// ==== bench/uart_control_two_sva.sv ====
// Port-level assertions for the serial control block
`timescale 1ns/100ps
`default_nettype none
module uart_control_two_sva
    import uart_control_two_pkg::*;
#(
    parameter int BIT_CYCLES = 16
) (
    // Clock and reset
    input wire logic                          pclk,
    input wire logic                          presetn,
    // APB
    input wire uart_control_two_pkg::apb_addr_t paddr,
    input wire logic                          psel,
    input wire logic                          penable,
    input wire logic                          pwrite,
    input wire logic [31:0]                   pwdata,
    input wire logic [31:0]                   prdata,
    input wire logic                          pready,
    input wire logic                          pslverr,
    // Pins and interrupt
    input wire logic                          tx_pin_out,
    input wire logic                          tx_pin_oe,
    input wire logic                          rx_pin_claim,
    input wire logic                          irq
);
    logic [7:0] c1q;
    logic [7:0] c2q;
    logic [2:0] evq;
    int         low_cnt;
    logic       sw_in;
    // Shadows follow software writes; hardware-cleared standby is never compared
    assign sw_in = c1q[7] && c1q[5] && !c1q[0];
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {c1q, c2q, evq} <= '0;
            low_cnt <= 0;
        end else begin
            low_cnt <= tx_pin_out ? 0 : low_cnt + 1;
            if (psel && penable && pwrite && paddr == 8'h00) c1q <= pwdata[7:0];
            if (psel && penable && pwrite && paddr == 8'h04) c2q <= pwdata[7:0];
            if (psel && penable && pwrite && paddr == 8'h18) evq <= pwdata[2:0];
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_always: assert property (psel && penable |-> pready)
        else $error("access phase without ready");
    a_ctrl_read: assert property (psel && penable && !pwrite && paddr == 8'h04
        |-> prdata[31:2] == {24'h0, c2q[7:2]} && !pslverr) else $error("control readback");
    a_unmapped_err: assert property (psel && penable && paddr > 8'h18 |-> pslverr)
        else $error("unmapped access not flagged");
    a_irq_masked: assert property (c2q[7:4] == 4'h0 && evq == 3'h0 |-> !irq)
        else $error("interrupt with all enables off");
    a_rx_claim: assert property (rx_pin_claim == (c2q[2] && !c1q[7]))
        else $error("receive pin ownership wrong");
    a_tx_own: assert property (c2q[3] && !sw_in |-> tx_pin_oe)
        else $error("transmit pin not driven");
    a_one_wire_in: assert property (sw_in |-> !tx_pin_oe)
        else $error("pin driven in single-wire input");
    a_oe_in_frame: assert property (!tx_pin_out && !sw_in |-> tx_pin_oe)
        else $error("low bit sent on released pin");
    a_pin_release: assert property ($fell(c2q[3]) && !c2q[0]
        |-> ##[0:800] (!tx_pin_oe || c2q[3])) else $error("pin never released");
    a_low_run_max: assert property (low_cnt <= (c1q[1] ? 14 : 11) * BIT_CYCLES)
        else $error("low run too long");
    cover property ($rose(irq));
    cover property ($fell(tx_pin_oe));
    cover property (sw_in && c2q[3]);
endmodule
`default_nettype wire

// ==== bench/serial_node.sv ====
// Remote serial node: sends frames, decodes frames and breaks
`timescale 1ns/100ps
`default_nettype none
module serial_node #(
    parameter int BC = 4
) (
    input  wire logic pclk,
    input  wire logic line_in,
    output logic      line_out
);
    logic [7:0] rx_q[$];
    int         brk_q[$];
    logic [9:0] b;
    int         t;
    // Line rests high between frames, as a pulled-up wire would
    initial line_out = 1'b1;
    task automatic send(input logic [7:0] d);
        logic [9:0] f;
        f = {1'b1, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge pclk);
            line_out <= f[i];
            repeat (BC - 1) @(posedge pclk);
        end
        @(posedge pclk);
    endtask
    // Stop bit judged at mid-bit so a frame right behind is not missed
    initial forever begin
        @(negedge line_in);
        repeat (BC / 2) @(posedge pclk);
        for (int i = 0; i < 10; i++) begin
            b[i] = line_in;
            if (i < 9) repeat (BC) @(posedge pclk);
        end
        if (b == 10'h000) begin
            t = BC / 2 + 9 * BC;
            while (line_in === 1'b0) begin
                @(posedge pclk);
                t++;
            end
            brk_q.push_back(t / BC);
        end else rx_q.push_back(b[8:1]);
    end
endmodule
`default_nettype wire

// ==== bench/uart_control_two_tb_top.sv ====
// Testbench top: APB master, serial partner and reference checks
`timescale 1ns/100ps
`default_nettype none
module uart_control_two_tb_top;
    import uart_control_two_pkg::*;
    localparam int BC = 4;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        tx_pin_out, tx_pin_oe, rx_line, rx_pin_claim, irq, err_q;
    apb_addr_t   paddr;
    logic [31:0] pwdata, prdata, rd_q, d;
    int          n_errors, n_compared, seed, cyc;
    wire         tx_wire;
    // Released pin floats to the pull-up level
    assign tx_wire = tx_pin_oe ? tx_pin_out : 1'b1;
    uart_control_two #(.BIT_CYCLES(BC)) dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .tx_pin_out(tx_pin_out), .tx_pin_oe(tx_pin_oe),
        .tx_pin_in(tx_wire), .rx_pin_in(rx_line), .rx_pin_claim(rx_pin_claim), .irq(irq));
    serial_node #(.BC(BC)) node (.pclk(pclk), .line_in(tx_wire), .line_out(rx_line));
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    // Run ceiling: a hang counts as a mismatch
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            close_out();
        end
    end
    task automatic close_out();
        $display("compared %0d, errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input apb_addr_t a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        // Answer taken at the completing edge, before any register update lands
        rd_q = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // One more edge so callers look at what the access changed
        @(posedge pclk);
    endtask
    task automatic rdc(input apb_addr_t a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd_q, e);
    endtask
    task automatic wq();
        for (int i = 0; i < 4000 && node.rx_q.size() + node.brk_q.size() == 0; i++)
            @(posedge pclk);
    endtask
    initial begin
        {psel, penable, pwrite, presetn} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        {n_errors, n_compared, cyc, seed} = {32'd0, 32'd0, 32'd0, 32'd26};
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rdc(8'h04, 32'h0);
        rdc(8'h08, 32'hC);
        apb(1'b0, 8'h1C, 32'h0);
        chk({31'h0, err_q}, 32'h1);
        for (int j = 2; j < 8; j++) begin
            apb(1'b1, 8'h04, 32'h1 << j);
            // Let the idle character queued by raising transmit enable run out
            if (j == 3) repeat (12 * BC) @(posedge pclk);
            chk({31'h0, irq}, {31'h0, j >= 6});
            rdc(8'h04, 32'h1 << j);
        end
        apb(1'b1, 8'h04, 32'h48);
        for (int k = 0; k < 3; k++) begin
            d = $random(seed) & 32'hFF;
            apb(1'b1, 8'h0C, d);
            if (k == 2) apb(1'b1, 8'h04, 32'h40);
            chk({31'h0, tx_pin_oe}, 32'h1);
            chk({31'h0, irq}, 32'h0);
            wq();
            chk({24'h0, node.rx_q.pop_front()}, d);
        end
        repeat (3 * BC) @(posedge pclk);
        chk({31'h0, tx_pin_oe}, 32'h0);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, 8'h04, 32'h08);
        for (int k = 0; k < 2; k++) begin
            apb(1'b1, 8'h00, k << 1);
            apb(1'b1, 8'h04, 32'h09);
            apb(1'b1, 8'h04, 32'h08);
            wq();
            chk(node.brk_q.pop_front(), k ? 13 : 10);
        end
        rdc(8'h10, 32'h1);
        apb(1'b1, 8'h18, 32'h1);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, 8'h14, 32'h1);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, 8'h04, 32'h24);
        d = $random(seed) & 32'hFF;
        node.send(d[7:0]);
        repeat (2 * BC) @(posedge pclk);
        chk({31'h0, irq}, 32'h1);
        rdc(8'h0C, d);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, 8'h04, 32'h14);
        repeat (12 * BC) @(posedge pclk);
        chk({31'h0, irq}, 32'h1);
        rdc(8'h08, 32'hD);
        apb(1'b0, 8'h0C, 32'h0);
        repeat (12 * BC) @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, 8'h00, 32'h08);
        apb(1'b1, 8'h04, 32'h06);
        node.send(8'h12);
        repeat (2 * BC) @(posedge pclk);
        rdc(8'h04, 32'h06);
        node.send(8'h85);
        repeat (2 * BC) @(posedge pclk);
        rdc(8'h04, 32'h04);
        rdc(8'h0C, 32'h85);
        apb(1'b1, 8'h00, 32'h00);
        apb(1'b1, 8'h04, 32'h06);
        node.send(8'h33);
        repeat (14 * BC) @(posedge pclk);
        rdc(8'h04, 32'h04);
        apb(1'b1, 8'h04, 32'h0C);
        chk({31'h0, rx_pin_claim}, 32'h1);
        apb(1'b1, 8'h00, 32'h80);
        chk({31'h0, rx_pin_claim}, 32'h0);
        apb(1'b1, 8'h00, 32'hA0);
        chk({31'h0, tx_pin_oe}, 32'h0);
        apb(1'b1, 8'h00, 32'hA1);
        chk({31'h0, tx_pin_oe}, 32'h1);
        close_out();
    end
endmodule
bind uart_control_two uart_control_two_sva #(.BIT_CYCLES(BIT_CYCLES)) chk_i (.pclk(pclk),
    .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_pin_out(tx_pin_out), .tx_pin_oe(tx_pin_oe), .rx_pin_claim(rx_pin_claim), .irq(irq));
`default_nettype wire
